// >>> hw/hbm_defs.svh
/*
 * offsets, field positions, reset values and encodings of the host bus master port.
 * assumes the includer applies them to 32-bit ahb-lite word registers.
 */
`ifndef HBM_DEFS_SVH
`define HBM_DEFS_SVH
// register byte offsets
`define HBM_MODE_OFS 12'h000
`define HBM_STAT_OFS 12'h004
// mode register fields
`define HBM_MODE_OVR_BIT 0
`define HBM_MODE_ATM_BIT 1
`define HBM_MODE_ASX_BIT 2
`define HBM_MODE_UPV_LSB 4
`define HBM_MODE_UPV_MSB 7
`define HBM_MODE_RST 32'h0000_0000
// status register fields
`define HBM_STAT_BUSY_BIT 0
`define HBM_STAT_OWN_BIT 1
`define HBM_STAT_PERR_BIT 2
// transfer size codes
`define HBM_SIZ_WORD 3'h0
`define HBM_SIZ_B16 3'h4
`define HBM_SIZ_B32 3'h5
// beats per transfer, minus one
`define HBM_LAST_WORD 4'h0
`define HBM_LAST_B16 4'h3
`define HBM_LAST_B32 4'h7
`endif

// >>> hw/hbm_pkg.sv
/*
 * types shared by the host bus master port files.
 * assumes hbm_defs.svh is on the include path.
 */
`default_nettype none
`include "hbm_defs.svh"
package hbm_pkg;
    typedef enum {hbm_idle, hbm_req, hbm_addr, hbm_data, hbm_recov} hbm_state_t;
    typedef enum logic [1:0] {hbm_single = 2'h0, hbm_quad = 2'h1, hbm_oct = 2'h2} hbm_burst_t;
    // transaction codes on the top address nibble
    typedef enum logic [3:0] {
        hbm_fc_tx1_data = 4'h0, hbm_fc_tx1_desc = 4'h1, hbm_fc_tx1_req = 4'h2,
        hbm_fc_tx0_data = 4'h3, hbm_fc_tx0_desc = 4'h4, hbm_fc_tx0_req = 4'h5,
        hbm_fc_rx2_data = 4'h6, hbm_fc_rx2_desc = 4'h7, hbm_fc_rx2_pool = 4'h8,
        hbm_fc_rx1_data = 4'h9, hbm_fc_rx1_desc = 4'hA, hbm_fc_rx1_pool = 4'hB,
        hbm_fc_rx0_data = 4'hC, hbm_fc_rx0_desc = 4'hD, hbm_fc_rx0_pool = 4'hE,
        hbm_fc_ptr_mem = 4'hF
    } hbm_fcode_t;
    function automatic logic [2:0] hbm_size_of(input logic [1:0] b);
        hbm_size_of = (b == hbm_oct) ? `HBM_SIZ_B32 : (b == hbm_quad) ? `HBM_SIZ_B16 : `HBM_SIZ_WORD;
    endfunction
    function automatic logic [3:0] hbm_last_of(input logic [1:0] b);
        hbm_last_of = (b == hbm_oct) ? `HBM_LAST_B32 : (b == hbm_quad) ? `HBM_LAST_B16 : `HBM_LAST_WORD;
    endfunction
endpackage
`default_nettype wire

// >>> hw/hbm_parity.sv
/*
 * byte-lane parity generator for a multiplexed bus word.
 * assumes a width that is a whole number of bytes.
 */
`default_nettype none
module hbm_parity #(
    parameter int WIDTH = 32,
    parameter bit ODD = 1'b1
) (
    // word in
    input wire logic [WIDTH-1:0] word,
    // one parity bit per byte lane
    output logic [WIDTH/8-1:0] lane_par
);
    if (WIDTH % 8 != 0 || WIDTH < 8)
    begin : g_bad
        $error("hbm_parity width must be whole bytes");
    end
    ////////////////////////////////////////////////////////////////////////
    // lane n covers bits 8n+7 down to 8n
    always_comb
    begin
        for (int i = 0; i < WIDTH / 8; i++)
        begin
            lane_par[i] = (^word[i*8 +: 8]) ^ ODD;
        end
    end
endmodule // hbm_parity
`default_nettype wire

// >>> hw/hbm_regs.sv
/*
 * ahb-lite slave holding the mode and status registers of the port.
 * assumes it is the only slave: its hreadyout is the bus hready.
 */
`default_nettype none
`include "hbm_defs.svh"
module hbm_regs (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // block state
    input wire logic busy,
    input wire logic owns_bus,
    input wire logic perr_pulse,
    // mode fields
    output logic [31:0] mode
);
    logic wr_pend, next_wr_pend, perr, next_perr;
    logic [11:0] wr_ofs, next_wr_ofs;
    logic [31:0] next_mode, next_hrdata;
    logic take;
    ////////////////////////////////////////////////////////////////////////
    // zero wait states, always okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign take = hsel && htrans[1] && hready;
    // address phase capture, write in data phase, read data registered
    always_comb
    begin
        next_wr_pend = take && hwrite;
        next_wr_ofs = take ? haddr[11:0] : wr_ofs;
        next_mode = mode;
        next_perr = perr;
        next_hrdata = 32'h0000_0000;
        if (wr_pend && wr_ofs == `HBM_MODE_OFS)
            next_mode = hwdata;
        if (wr_pend && wr_ofs == `HBM_STAT_OFS && hwdata[`HBM_STAT_PERR_BIT])
            next_perr = 1'b0;
        // a fresh error wins over a clear in the same cycle
        if (perr_pulse)
            next_perr = 1'b1;
        if (take && !hwrite && haddr[11:0] == `HBM_MODE_OFS)
            next_hrdata = mode;
        else if (take && !hwrite && haddr[11:0] == `HBM_STAT_OFS)
        begin
            next_hrdata[`HBM_STAT_BUSY_BIT] = busy;
            next_hrdata[`HBM_STAT_OWN_BIT] = owns_bus;
            next_hrdata[`HBM_STAT_PERR_BIT] = perr;
        end
    end
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend <= 1'b0;
            wr_ofs <= 12'h000;
            mode <= `HBM_MODE_RST;
            perr <= 1'b0;
            hrdata <= 32'h0000_0000;
        end
        else
        begin
            wr_pend <= next_wr_pend;
            wr_ofs <= next_wr_ofs;
            mode <= next_mode;
            perr <= next_perr;
            hrdata <= next_hrdata;
        end
    end
endmodule // hbm_regs
`default_nettype wire

// >>> hw/hbm_port.sv
/*
 * host bus master port: moves dma words over a multiplexed address/data bus
 * with byte parity, a demultiplexed word address and request/grant ownership.
 * assumes an external arbiter, a memory that acknowledges each data beat,
 * and an ahb-lite master for the mode and status registers.
 */
// Local design decisions: the address map and the AHB-Lite interface to the registers.
`default_nettype none
`include "hbm_defs.svh"
module hbm_port #(
    parameter bit PAR_ODD = 1'b1
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite register slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // dma channel request
    input wire logic dma_req,
    input wire logic dma_write,
    input wire logic [3:0] dma_func,
    input wire logic [25:0] dma_word_addr,
    input wire logic [1:0] dma_burst,
    output logic dma_ready,
    input wire logic [31:0] dma_wdata,
    output logic dma_wdata_take,
    output logic [31:0] dma_rdata,
    output logic dma_rdata_valid,
    output logic dma_done,
    // arbitration
    output logic bus_request,
    input wire logic bus_grant,
    // multiplexed address/data with parity
    output logic [31:0] muxed_addr_data_out,
    output logic muxed_addr_data_oe_n,
    input wire logic [31:0] muxed_addr_data_in,
    output logic [3:0] bus_byte_parity_out,
    output logic bus_byte_parity_oe_n,
    input wire logic [3:0] bus_byte_parity_in,
    // demultiplexed word address
    output logic [25:0] demuxed_word_addr,
    output logic demuxed_word_addr_oe_n,
    // bus control
    output logic address_strobe,
    output logic read_write_dir,
    output logic [2:0] transfer_size,
    output logic bus_ctrl_oe_n,
    input wire logic bus_acknowledge
);
    hbm_pkg::hbm_state_t state, next_state;
    logic [25:0] start_addr, next_start_addr, cur_addr, next_cur_addr;
    logic [3:0] beats_left, next_beats_left, fcode, next_fcode;
    logic [2:0] size, next_size;
    logic is_write, next_is_write, asx_cnt, next_asx_cnt;
    logic [31:0] wdata, next_wdata, next_rdata;
    logic next_rvalid, next_done, perr_pulse;
    logic [31:0] mode;
    logic mode_ovr, mode_atm, mode_asx;
    logic [3:0] mode_upv, in_par;
    logic owns_bus;
    ////////////////////////////////////////////////////////////////////////
    // registers; hsize is ignored, every access is taken as a word
    hbm_regs u_regs (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hrdata(hrdata),
        .hresp(hresp),
        .busy(state != hbm_pkg::hbm_idle),
        .owns_bus(owns_bus),
        .perr_pulse(perr_pulse),
        .mode(mode)
    );
    assign mode_ovr = mode[`HBM_MODE_OVR_BIT];
    assign mode_atm = mode[`HBM_MODE_ATM_BIT];
    assign mode_asx = mode[`HBM_MODE_ASX_BIT];
    assign mode_upv = mode[`HBM_MODE_UPV_MSB:`HBM_MODE_UPV_LSB];
    ////////////////////////////////////////////////////////////////////////
    // transfer sequencer: idle, request, address, data beats, recovery
    always_comb
    begin
        next_state = state;
        next_start_addr = start_addr;
        next_cur_addr = cur_addr;
        next_beats_left = beats_left;
        next_fcode = fcode;
        next_size = size;
        next_is_write = is_write;
        next_asx_cnt = asx_cnt;
        next_wdata = wdata;
        next_rdata = dma_rdata;
        next_rvalid = 1'b0;
        next_done = 1'b0;
        perr_pulse = 1'b0;
        dma_wdata_take = 1'b0;
        case (state)
            hbm_pkg::hbm_idle:
            begin
                if (dma_req)
                begin
                    // page addresses pass through untranslated
                    next_start_addr = dma_word_addr;
                    next_cur_addr = dma_word_addr;
                    next_fcode = dma_func;
                    next_is_write = dma_write;
                    next_size = hbm_pkg::hbm_size_of(dma_burst);
                    next_beats_left = hbm_pkg::hbm_last_of(dma_burst);
                    next_state = hbm_pkg::hbm_req;
                end
            end
            hbm_pkg::hbm_req:
            begin
                if (bus_grant)
                begin
                    next_asx_cnt = mode_asx;
                    next_state = hbm_pkg::hbm_addr;
                end
            end
            hbm_pkg::hbm_addr:
            begin
                if (asx_cnt)
                    next_asx_cnt = 1'b0; // stretched strobe, one more cycle
                else
                begin
                    next_state = hbm_pkg::hbm_data;
                    dma_wdata_take = is_write;
                    if (is_write)
                        next_wdata = dma_wdata;
                end
            end
            hbm_pkg::hbm_data:
            begin
                if (bus_acknowledge)
                begin
                    if (!is_write)
                    begin
                        next_rdata = muxed_addr_data_in;
                        next_rvalid = 1'b1;
                        perr_pulse = (in_par != bus_byte_parity_in);
                    end
                    if (beats_left == 4'h0)
                    begin
                        // strobe is low here, so acknowledge leads to recovery
                        next_state = hbm_pkg::hbm_recov;
                        next_done = 1'b1;
                    end
                    else
                    begin
                        next_beats_left = beats_left - 4'h1;
                        next_cur_addr = cur_addr + 26'h1;
                        dma_wdata_take = is_write;
                        if (is_write)
                            next_wdata = dma_wdata;
                    end
                end
            end
            hbm_pkg::hbm_recov:
            begin
                // request dropped so the arbiter can regrant afterwards
                next_state = hbm_pkg::hbm_idle;
            end
            default:
            begin
                next_state = hbm_pkg::hbm_idle;
            end
        endcase
    end
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state <= hbm_pkg::hbm_idle;
            start_addr <= 26'h0000000;
            cur_addr <= 26'h0000000;
            beats_left <= 4'h0;
            fcode <= 4'h0;
            size <= `HBM_SIZ_WORD;
            is_write <= 1'b0;
            asx_cnt <= 1'b0;
            wdata <= 32'h0000_0000;
            dma_rdata <= 32'h0000_0000;
            dma_rdata_valid <= 1'b0;
            dma_done <= 1'b0;
        end
        else
        begin
            state <= next_state;
            start_addr <= next_start_addr;
            cur_addr <= next_cur_addr;
            beats_left <= next_beats_left;
            fcode <= next_fcode;
            size <= next_size;
            is_write <= next_is_write;
            asx_cnt <= next_asx_cnt;
            wdata <= next_wdata;
            dma_rdata <= next_rdata;
            dma_rdata_valid <= next_rvalid;
            dma_done <= next_done;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // bus drive, all decoded from registered state
    assign dma_ready = (state == hbm_pkg::hbm_idle);
    assign bus_request = (state == hbm_pkg::hbm_req);
    assign owns_bus = (state == hbm_pkg::hbm_addr) || (state == hbm_pkg::hbm_data)
        || (state == hbm_pkg::hbm_recov);
    assign address_strobe = (state == hbm_pkg::hbm_addr);
    assign read_write_dir = !is_write;
    assign transfer_size = size;
    assign bus_ctrl_oe_n = !owns_bus;
    // low two address bits have no pins and are zero on the muxed lines
    always_comb
    begin
        if (state == hbm_pkg::hbm_addr)
        begin
            muxed_addr_data_out[27:0] = {start_addr, 2'b00};
            muxed_addr_data_out[31:28] = mode_ovr ? mode_upv : fcode;
        end
        else
            muxed_addr_data_out = is_write ? wdata : 32'h0000_0000;
    end
    assign muxed_addr_data_oe_n = !((state == hbm_pkg::hbm_addr)
        || (state == hbm_pkg::hbm_data && is_write));
    assign bus_byte_parity_oe_n = muxed_addr_data_oe_n;
    // timing bit set: address tracks each beat; clear: holds the start word
    always_comb
    begin
        if (state == hbm_pkg::hbm_recov)
            demuxed_word_addr = 26'h0000000;
        else
            demuxed_word_addr = mode_atm ? cur_addr : start_addr;
    end
    assign demuxed_word_addr_oe_n = !owns_bus;
    // parity generated on the way out and checked on the way in
    hbm_parity #(.WIDTH(32), .ODD(PAR_ODD)) u_par_out (
        .word(muxed_addr_data_out),
        .lane_par(bus_byte_parity_out)
    );
    hbm_parity #(.WIDTH(32), .ODD(PAR_ODD)) u_par_in (
        .word(muxed_addr_data_in),
        .lane_par(in_par)
    );
    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_last_ack;
        state == hbm_pkg::hbm_data && bus_acknowledge && beats_left == 4'h0;
    endsequence
    sequence s_recover_release;
        state == hbm_pkg::hbm_recov && !address_strobe && demuxed_word_addr == 26'h0000000
            ##1 demuxed_word_addr_oe_n && muxed_addr_data_oe_n;
    endsequence
    a_addr_low_lines: assert property (@(posedge hclk) disable iff (!hresetn)
        state == hbm_pkg::hbm_addr |-> muxed_addr_data_out[27:0] == {start_addr, 2'b00})
        else $error("address lines do not carry the start address");
    a_upper_override: assert property (@(posedge hclk) disable iff (!hresetn)
        state == hbm_pkg::hbm_addr && mode_ovr |-> muxed_addr_data_out[31:28] == mode_upv)
        else $error("override value missing from top nibble");
    a_upper_fcode: assert property (@(posedge hclk) disable iff (!hresetn)
        state == hbm_pkg::hbm_addr && !mode_ovr |-> muxed_addr_data_out[31:28] == fcode)
        else $error("function code missing from top nibble");
    a_recovery_next: assert property (@(posedge hclk) disable iff (!hresetn)
        s_last_ack |=> s_recover_release)
        else $error("last acknowledge not followed by recovery and release");
    a_grant_strobe: assert property (@(posedge hclk) disable iff (!hresetn)
        state == hbm_pkg::hbm_req && bus_grant |=> address_strobe && !muxed_addr_data_oe_n
            && muxed_addr_data_out[27:0] == {start_addr, 2'b00})
        else $error("grant not followed by strobed address");
    a_size_legal: assert property (@(posedge hclk) disable iff (!hresetn)
        !bus_ctrl_oe_n |-> transfer_size inside {`HBM_SIZ_WORD, `HBM_SIZ_B16, `HBM_SIZ_B32})
        else $error("reserved size driven");
    a_release_idle: assert property (@(posedge hclk) disable iff (!hresetn)
        !owns_bus |-> bus_ctrl_oe_n && muxed_addr_data_oe_n && demuxed_word_addr_oe_n)
        else $error("bus driven without ownership");
    a_parity_lanes: assert property (@(posedge hclk) disable iff (!hresetn)
        !bus_byte_parity_oe_n |-> bus_byte_parity_out[1] == ((^muxed_addr_data_out[15:8])
            ^ PAR_ODD))
        else $error("lane one parity wrong");
    a_burst_step: assert property (@(posedge hclk) disable iff (!hresetn)
        state == hbm_pkg::hbm_data && bus_acknowledge && beats_left != 4'h0
            |=> cur_addr == $past(cur_addr) + 26'h1 && state == hbm_pkg::hbm_data)
        else $error("burst word address did not advance");
    // recovery shows a zero word address, still driven
    a_wordaddr_neg: assert property (@(posedge hclk) disable iff (!hresetn)
        state == hbm_pkg::hbm_recov |-> demuxed_word_addr == 26'h0000000
            && !demuxed_word_addr_oe_n)
        else $error("word address not negated in recovery");
    // later beats show the next word only with the timing bit set
    a_wordaddr_beat: assert property (@(posedge hclk) disable iff (!hresetn)
        state == hbm_pkg::hbm_data && bus_acknowledge && beats_left != 4'h0
            |=> demuxed_word_addr == (mode_atm ? $past(demuxed_word_addr) + 26'h1
            : start_addr))
        else $error("word address wrong after a beat");
    sequence s_waiting;
        bus_request && !bus_grant;
    endsequence
    // the request stands, bus untouched, until the grant is seen
    a_request_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        s_waiting |=> bus_request && bus_ctrl_oe_n)
        else $error("request dropped before grant");
    // the two missing address bits read as zero
    a_word_aligned: assert property (@(posedge hclk) disable iff (!hresetn)
        address_strobe |-> muxed_addr_data_out[1:0] == 2'b00)
        else $error("address not word aligned");
endmodule // hbm_port
`default_nettype wire

// >>> sim/hbm_host_model.sv
/* host side of the port: arbiter and a counting read-data source that acknowledges each beat.
   assumes the bench resolves the shared lines from the oe_n outputs. */
`default_nettype none
module hbm_host_model (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // port bus outputs
    input wire logic bus_request,
    input wire logic address_strobe,
    input wire logic bus_ctrl_oe_n,
    input wire logic read_write_dir,
    input wire logic [2:0] transfer_size,
    // bench controls
    input wire logic slow,
    input wire logic bad_par,
    // answers
    output logic bus_grant,
    output logic bus_acknowledge,
    output logic [31:0] rd_data,
    output logic [3:0] rd_par
);
    timeunit 1ns;
    timeprecision 1ns;
    logic active, go;
    logic [3:0] left;
    logic [23:0] k;
    // ack only in data states, never under the strobe
    assign bus_acknowledge = active & ~address_strobe & go;
    // idle lines show the inverse, so a stale value cannot pass
    assign rd_data = bus_acknowledge ? {8'hA5, k} : ~{8'hA5, k};
    assign rd_par = {~^rd_data[31:24], ~^rd_data[23:16], ~^rd_data[15:8],
        bad_par ^ ~^rd_data[7:0]};
    // grant after request; dropped only once the port has let go
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            active <= 1'b0;
            go <= 1'b0;
            left <= 4'h0;
            k <= 24'h0;
            bus_grant <= 1'b0;
        end
        else
        begin
            go <= ~slow | ($urandom % 2 == 1);
            if (bus_request & ~bus_grant)
                bus_grant <= ~slow | ($urandom % 2 == 1);
            else if (bus_ctrl_oe_n & ~bus_request)
                bus_grant <= 1'b0;
            if (address_strobe & ~bus_ctrl_oe_n & ~active)
            begin
                active <= 1'b1;
                left <= (transfer_size == 3'h5) ? 4'h8 : (transfer_size == 3'h4) ? 4'h4 : 4'h1;
            end
            else if (bus_acknowledge)
            begin
                left <= left - 4'h1;
                active <= (left != 4'h1);
            end
            if (bus_acknowledge & read_write_dir)
                k <= k + 24'h1;
        end
    end
endmodule // hbm_host_model
`default_nettype wire

// >>> sim/tb.sv
/* self-checking bench for hbm_port with the host model.
   assumes hbm_defs.svh on the include path and a zero-wait slave. */
`default_nettype none
`include "hbm_defs.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, slow, bad_par, as_q;
    logic [1:0] htrans, dma_burst;
    logic [2:0] hsize, transfer_size;
    logic [31:0] haddr, hwdata, hrdata, dma_wdata, dma_rdata, mo, mi, rd_data, wbase, r, mv;
    logic dma_req, dma_write, dma_ready, dma_wdata_take, dma_rdata_valid, dma_done;
    logic bus_request, bus_grant, mo_n, par_n, wa_n, address_strobe, read_write_dir;
    logic ctl_n, bus_acknowledge, ovr, exp_w;
    logic [3:0] dma_func, po, pi, rd_par, upv, exp_top;
    logic [25:0] dma_word_addr, demuxed_word_addr, exp_wa;
    logic [2:0] exp_siz;
    int err_count, checks, wt, wn, rn;
    // shared lines: whoever enables wins
    assign mi = mo_n ? rd_data : mo;
    assign pi = par_n ? rd_par : po;
    assign hready = hreadyout;
    assign dma_wdata = wbase + wt;
    hbm_port u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .dma_req(dma_req),
        .dma_write(dma_write), .dma_func(dma_func), .dma_word_addr(dma_word_addr),
        .dma_burst(dma_burst), .dma_ready(dma_ready), .dma_wdata(dma_wdata),
        .dma_wdata_take(dma_wdata_take), .dma_rdata(dma_rdata),
        .dma_rdata_valid(dma_rdata_valid), .dma_done(dma_done), .bus_request(bus_request),
        .bus_grant(bus_grant), .muxed_addr_data_out(mo), .muxed_addr_data_oe_n(mo_n),
        .muxed_addr_data_in(mi), .bus_byte_parity_out(po), .bus_byte_parity_oe_n(par_n),
        .bus_byte_parity_in(pi), .demuxed_word_addr(demuxed_word_addr),
        .demuxed_word_addr_oe_n(wa_n), .address_strobe(address_strobe),
        .read_write_dir(read_write_dir), .transfer_size(transfer_size),
        .bus_ctrl_oe_n(ctl_n), .bus_acknowledge(bus_acknowledge));
    hbm_host_model u_host (.hclk(hclk), .hresetn(hresetn), .bus_request(bus_request),
        .address_strobe(address_strobe), .bus_ctrl_oe_n(ctl_n),
        .read_write_dir(read_write_dir), .transfer_size(transfer_size), .slow(slow),
        .bad_par(bad_par), .bus_grant(bus_grant), .bus_acknowledge(bus_acknowledge),
        .rd_data(rd_data), .rd_par(rd_par));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [39:0] e, input logic [39:0] s);
        checks++;
        if (e !== s)
        begin
            err_count++;
            $display("BAD %s exp=%h got=%h", n, e, s);
        end
    endtask
    task automatic finish_test;
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // odd parity per byte lane
    function automatic logic [3:0] par(input logic [31:0] v);
        for (int i = 0; i < 4; i++)
            par[i] = ~^v[8*i+:8];
    endfunction
    function automatic logic [2:0] sz(input logic [1:0] b);
        sz = (b == 2'h1) ? 3'h4 : (b == 2'h2) ? 3'h5 : 3'h0;
    endfunction
    // one ahb-lite single word; entered and left at a rising edge
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        r = hrdata;
        chk("resp", 0, hresp);
    endtask
    // one dma transfer, then wait for its done pulse under a bound
    task automatic xfer(input logic w, input logic [3:0] f, input logic [1:0] b);
        int n;
        n = 0;
        while (dma_ready !== 1'b1) @(posedge hclk);
        exp_w = w;
        exp_wa = 26'($urandom);
        exp_siz = sz(b);
        exp_top = ovr ? upv : f;
        dma_req <= 1'b1;
        dma_write <= w;
        dma_func <= f;
        dma_word_addr <= exp_wa;
        dma_burst <= b;
        @(posedge hclk);
        dma_req <= 1'b0;
        while (dma_done !== 1'b1 && n < 300)
        begin
            @(posedge hclk);
            n++;
        end
        chk("done", 1, n < 300);
    endtask
    always @(posedge hclk)
        if (dma_wdata_take === 1'b1)
            wt <= wt + 1;
    // bus watcher: settled values at the falling edge
    always @(negedge hclk)
        if (hresetn)
        begin
            if (address_strobe === 1'b1 && as_q !== 1'b1)
            begin
                chk("top", exp_top, mo[31:28]);
                chk("addr", {exp_wa, 2'h0}, mo[27:0]);
                chk("size", exp_siz, transfer_size);
                chk("dir", !exp_w, read_write_dir);
                chk("apar", par(mo), po);
                chk("wa", exp_wa, demuxed_word_addr);
                chk("own", 4'h0, {mo_n, par_n, wa_n, ctl_n});
            end
            as_q = address_strobe;
            if (bus_acknowledge && !exp_w)
                chk("rdrel", 1, mo_n);
            if (bus_acknowledge && exp_w)
            begin
                chk("wdat", {1'b0, wbase + wn}, {mo_n, mo});
                wn++;
            end
            if (dma_rdata_valid === 1'b1)
            begin
                chk("rdat", {8'hA5, rn[23:0]}, dma_rdata);
                rn++;
            end
            if (dma_done === 1'b1)
                chk("recov", 0, {address_strobe, wa_n, demuxed_word_addr});
            if (bus_grant === 1'b0)
                chk("rel", 4'hF, {mo_n, par_n, wa_n, ctl_n});
        end
    initial
    begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end
    initial
    begin
        #6000000;
        err_count++;
        finish_test;
    end
    initial
    begin
        {hresetn, hwrite, dma_req, dma_write, slow, bad_par, ovr, as_q} = 8'h0;
        {htrans, dma_burst, dma_func, dma_word_addr, upv, haddr, hwdata} = 0;
        {err_count, checks, wt, wn, rn} = 0;
        hsel = 1'b1;
        hsize = 3'h2;
        r = $urandom(37);
        wbase = $urandom;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        ahb(0, `HBM_MODE_OFS, 0);
        chk("mode_rst", 0, r);
        ahb(1, 32'h10, 32'hFFFF_FFFF);
        ahb(0, 32'h10, 0);
        chk("unmapped", 0, r);
        // every code, override clear then set, random timing and stalls
        for (int i = 0; i < 32; i++)
        begin
            ovr = i >= 16;
            upv = 4'($urandom);
            slow <= $urandom % 2;
            mv = {24'h0, upv, 1'b0, 1'($urandom), 1'($urandom), ovr};
            ahb(1, `HBM_MODE_OFS, mv);
            ahb(0, `HBM_MODE_OFS, 0);
            chk("mode_rb", mv, r);
            xfer(1'($urandom), 4'(i), 2'($urandom % 3));
            xfer(i % 2, 4'hF, 2'h2);
        end
        // bad read parity sets the sticky flag; write one clears it
        bad_par <= 1'b1;
        xfer(0, 4'hF, 2'h0);
        bad_par <= 1'b0;
        ahb(0, `HBM_STAT_OFS, 0);
        chk("perr", 32'h4, r);
        ahb(1, `HBM_STAT_OFS, 32'h4);
        ahb(0, `HBM_STAT_OFS, 0);
        chk("perr_clr", 0, r);
        finish_test;
    end
endmodule // tb
`default_nettype wire
